// >>> dv/shg_dev_model.sv
// Purpose: Behavioural serial peripheral facing the host glue
// Assumes: Strobes active low, one device in the chain
// Notes: Vector byte is arbitrary; bus shows inverted byte when not driven
`timescale 1ns/10ps
`default_nettype none
module shg_dev_model
   import shg_pkg::*;
#(
   parameter logic [7:0] VECTOR = 8'h5A
)
(
   // Strobes and chain
   input wire shg_periph_t i_periph,
   input wire logic i_chain_enable_in,
   input wire logic i_int_pending,
   input wire logic i_sw_clear,
   // Status
   output logic o_chain_enable_out,
   output logic o_chip_reset,
   output logic o_ius,
   output logic [7:0] o_data
);
   wire in_ack = ~i_periph.irq_acknowledge_n;
   wire ack_rd = in_ack & ~i_periph.rd_n;
   wire ack_rd_dly;
   // Both strobes low resets the chip
   assign o_chip_reset = ~i_periph.rd_n & ~i_periph.wr_n;
   // Vector valid 120 ns into the acknowledge read
   assign #120 ack_rd_dly = ack_rd;
   assign o_data = (ack_rd & ack_rd_dly & o_ius) ? VECTOR : ~VECTOR;
   // Pending only matters inside acknowledge
   assign o_chain_enable_out = i_chain_enable_in & ~o_ius & ~(in_ack & i_int_pending);
   // Under-service flag
   initial o_ius = 1'b0;
   always @(posedge ack_rd or posedge i_sw_clear)
   begin
      if (i_sw_clear)
         o_ius <= 1'b0;
      else if (i_int_pending && i_chain_enable_in)
         o_ius <= 1'b1;
   end
endmodule : shg_dev_model
`default_nettype wire

// >>> dv/tb_serial_ctrl_host_glue.sv
// Purpose: Self-checking bench for the host glue
// Assumes: Host bus driven on rising edge, outputs read at falling edge
// Notes: Output byte is {rd_n, wr_n, ack_n, wait_n} in the low nibble
`timescale 1ns/10ps
`default_nettype none
module tb_serial_ctrl_host_glue
   import shg_pkg::*;
   ;
   logic clk;
   logic rstn;
   logic sel;
   logic sys_rst;
   shg_host_bus_t bus;
   shg_host_bus_t hb;
   shg_periph_t periph;
   logic wait_n;
   shg_periph_t periph_f;
   logic wait_n_f;
   logic int_under_service;
   logic [7:0] want;
   logic crst;
   logic [7:0] vec;
   int err_total;
   int total_checks;
   // Clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   shg_host_glue uut (.I_CLK_SYS(clk), .I_RSTN(rstn), .I_HOST_BUS(bus),
      .I_PERIPHERAL_SELECT(sel), .I_SYS_RESET(sys_rst), .O_PERIPH(periph), .O_WAIT_N(wait_n));
   // Second glue without select flop and without reset gating
   shg_host_glue #(.USE_SYNC_FF(0), .HW_RESET_EN(0)) uut_fast (.I_CLK_SYS(clk), .I_RSTN(rstn),
      .I_HOST_BUS(bus), .I_PERIPHERAL_SELECT(sel), .I_SYS_RESET(sys_rst), .O_PERIPH(periph_f),
      .O_WAIT_N(wait_n_f));
   shg_dev_model dev (.i_periph(periph), .i_chain_enable_in(1'b1), .i_int_pending(1'b1),
      .i_sw_clear(1'b0), .o_chain_enable_out(), .o_chip_reset(crst), .o_ius(int_under_service), .o_data(vec));
   // Compare and count
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   function automatic logic [7:0] outs();
      return {4'h0, periph, wait_n};
   endfunction : outs
   function automatic logic [7:0] outs_f();
      return {4'h0, periph_f, wait_n_f};
   endfunction : outs_f
   task drv(input shg_host_bus_t b, input logic s);
      @(posedge clk);
      bus <= b;
      sel <= s;
   endtask : drv
   task step();
      @(posedge clk);
      @(negedge clk);
   endtask : step
   // Selected read or write, then early end
   task io(input logic rd_cyc);
      hb = 5'h1F;
      hb.io_request_n = 1'b0;
      hb.rd_n = ~rd_cyc;
      hb.wr_n = rd_cyc;
      drv(hb, 1'b1);
      step();
      chk(outs(), 8'h0F);
      chk(outs_f(), rd_cyc ? 8'h07 : 8'h0B);
      repeat (2)
      begin
         step();
         chk(outs(), rd_cyc ? 8'h07 : 8'h0B);
      end
      hb.rd_n = 1'b1;
      hb.wr_n = 1'b1;
      drv(hb, 1'b1);
      @(negedge clk);
      chk(outs(), 8'h0F);
      chk(outs_f(), 8'h0F);
      drv(5'h1F, 1'b0);
      step();
      $display("test io rd=%0b done", rd_cyc);
   endtask : io
   task stop_test();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   // Watchdog
   initial
   begin
      #(20 * 2000);
      err_total++;
      stop_test();
   end
   // Tests
   initial
   begin
      rstn = 1'b0;
      sel = 1'b0;
      sys_rst = 1'b0;
      bus = 5'h1F;
      err_total = 0;
      total_checks = 0;
      repeat (15) @(posedge clk);
      @(negedge clk);
      chk(outs(), 8'h0F);
      @(posedge clk);
      rstn <= 1'b1;
      io(1'b1);
      io(1'b0);
      // Normal fetch with memory read: nothing reaches the peripheral
      drv(5'h0C, 1'b0);
      repeat (3)
      begin
         step();
         chk(outs(), 8'h0F);
      end
      drv(5'h1F, 1'b0);
      step();
      $display("test fetch done");
      // Acknowledge: fetch without memory request
      drv(5'h1D, 1'b0);
      for (int k = 0; k < 16; k++)
      begin
         step();
         want = {4'h0, k < 7, 3'h0} | {7'h0, k >= 15} | 8'h04;
         chk(outs(), want);
      end
      chk(vec, 8'h5A);
      chk({7'h0, int_under_service}, 8'h01);
      chk(outs_f(), 8'h05);
      drv(5'h1F, 1'b0);
      step();
      chk(outs(), 8'h0F);
      $display("test acknowledge done");
      // System reset onto both strobes
      @(posedge clk);
      sys_rst <= 1'b1;
      @(negedge clk);
      chk(outs(), 8'h03);
      chk(outs_f(), 8'h0F);
      chk({7'h0, crst}, 8'h01);
      @(posedge clk);
      sys_rst <= 1'b0;
      @(negedge clk);
      chk(outs(), 8'h0F);
      $display("test system reset done");
      stop_test();
   end
endmodule : tb_serial_ctrl_host_glue
`default_nettype wire

// >>> hw/shg_host_glue.sv
// Purpose: Host-side glue from an 8-bit host bus to a serial controller
// Assumes: Host strobes synchronous to I_CLK_SYS; select decoded outside
// Notes: Sequencer taps and strobe delays derive from package timing
// Operation
// (RULE_01) Host runs legacy-compatible I/O strobe timing before glue is used.
// (RULE_02) Delay peripheral read fall so address setup reaches 50 ns.
// (RULE_03) Delay peripheral write fall so address setup reaches 50 ns.
// (RULE_04) End peripheral read before host read so address and select hold.
// (RULE_05) End peripheral write before host write so address and data hold.
// (RULE_06) Resample decoded select on rising clock edge when above 8 MHz.
// (RULE_07) System reset drives peripheral read and write low together.
// (RULE_08) Peripheral software reset value matches hardware reset effect.
// (RULE_09) Create acknowledge and read strobes, acknowledge first.
// (RULE_10) Hold host in wait until the vector is valid.
// (RULE_11) Leave daisy chain settle time between acknowledge and read.
// (RULE_12) Peripheral uses pending flag in chain only during acknowledge.
// (RULE_13) Peripheral clears under-service flags only by software command.
// (RULE_14) Peripheral treats read and write together as chip reset.
// (RULE_15) Chain output follows under-service flag, pending during acknowledge.
// (RULE_16) Peripheral sets under-service only with pending and chain enable.
// (RULE_17) Acknowledge delays counted in whole host clocks from sequencer taps.
// (RULE_18) Outside acknowledge keep sequencer clear, pass conditioned strobes.
// (RULE_19) Release wait only once the acknowledge read made vector valid.
`timescale 1ns/10ps
`default_nettype none
module shg_host_glue
   import shg_pkg::*;
#(
   parameter int USE_SYNC_FF = 1,
   parameter int HW_RESET_EN = 1,
   parameter int STROBE_DLY = STROBE_DLY_CYC,
   parameter int ACK_RD = ACK_RD_CYC,
   parameter int RD_VALID = RD_VALID_CYC
)
(
   // Clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_RSTN,
   // Host bus
   input wire shg_host_bus_t I_HOST_BUS,
   input wire logic I_PERIPHERAL_SELECT,
   input wire logic I_SYS_RESET,
   // Peripheral strobes
   output shg_periph_t O_PERIPH,
   // Host wait request, active low
   output logic O_WAIT_N
);
   localparam int WAIT_TAP = ACK_RD + RD_VALID;

   // Elaboration checks
   if (STROBE_DLY < 1) $error("shg_host_glue: STROBE_DLY must be at least 1");
   if (ACK_RD < 1) $error("shg_host_glue: ACK_RD must be at least 1");
   if (RD_VALID < RD_WIDTH_CYC) $error("shg_host_glue: RD_VALID below read width");
   if (WAIT_TAP > SEQ_LEN - 1) $error("shg_host_glue: sequencer too short");

   // Active-high view of a low-true strobe
   function automatic logic act(input logic strobe_n);
      act = ~strobe_n;
   endfunction : act

   // Host bus decode
   wire host_rd = act(I_HOST_BUS.rd_n);
   wire host_wr = act(I_HOST_BUS.wr_n);
   wire host_io = act(I_HOST_BUS.io_request_n);
   wire host_m1 = act(I_HOST_BUS.opcode_fetch_n);
   wire host_mem = act(I_HOST_BUS.mreq_n);
   wire raw_sel = I_PERIPHERAL_SELECT & host_io;

   // Select resample register
   // Host io_request may lag past half a clock; legacy-compatible host
   // strobe timing is assumed, so one rising-edge sample always catches it
   logic sel_q;
   always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
   begin
      if (!I_RSTN)
         sel_q <= 1'b0;
      else
         sel_q <= raw_sel; // [RULE_06] [RULE_01]
   end
   wire sel = (USE_SYNC_FF != 0) ? sel_q : raw_sel; // [RULE_06]

   // Requests for conditioned I/O strobes
   wire io_rd_req = sel & host_rd & ~host_m1;
   wire io_wr_req = sel & host_wr & ~host_m1;

   // Delay lines for the strobe falling edges
   logic [STROBE_DLY-1:0] rd_dly;
   logic [STROBE_DLY-1:0] wr_dly;
   wire [STROBE_DLY:0] next_rd_dly = {rd_dly, io_rd_req};
   wire [STROBE_DLY:0] next_wr_dly = {wr_dly, io_wr_req};
   always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         rd_dly <= '0;
         wr_dly <= '0;
      end
      else
      begin
         rd_dly <= io_rd_req ? next_rd_dly[STROBE_DLY-1:0] : '0; // [RULE_02]
         wr_dly <= io_wr_req ? next_wr_dly[STROBE_DLY-1:0] : '0; // [RULE_03]
      end
   end

   // Delayed start, early end: live request gates the delayed one
   // The strobe drops with the host strobe, so address and select still
   // stand for the peripheral's zero hold time after one gate delay
   wire io_rd_on = rd_dly[STROBE_DLY-1] & io_rd_req; // [RULE_02] [RULE_04]
   wire io_wr_on = wr_dly[STROBE_DLY-1] & io_wr_req; // [RULE_03] [RULE_05]

   // Early sign of acknowledge: opcode fetch without memory request
   // The host gives no acknowledge strobe of its own, so the sequencer
   // starts early and builds both strobes from whole host clocks
   wire ack_detect = host_m1 & ~host_mem;
   wire seq_clear = ~host_m1; // [RULE_18]
   logic [SEQ_LEN-1:0] stage;

   // Acknowledge sequencer
   shg_shift_reg #(
      .LEN(SEQ_LEN)
   ) u_seq (
      .i_clk(I_CLK_SYS),
      .i_rstn(I_RSTN),
      .i_clear(seq_clear),
      .i_din(ack_detect),
      .o_stage(stage)
   );

   // Sequencer taps, all in whole host clocks; reset request taken straight from I_SYS_RESET
   wire ack_on = stage[0]; // [RULE_09] [RULE_17]
   wire ack_rd_on = stage[ACK_RD]; // [RULE_09] [RULE_11] [RULE_17]
   wire wait_on = stage[0] & ~stage[WAIT_TAP]; // [RULE_10] [RULE_19]
   wire rst_on = (HW_RESET_EN != 0) & I_SYS_RESET; // [RULE_07]

   // Peripheral strobe and host wait outputs
   assign O_PERIPH.rd_n = ~(io_rd_on | ack_rd_on | rst_on); // [RULE_07] [RULE_18]
   assign O_PERIPH.wr_n = ~(io_wr_on | rst_on); // [RULE_07] [RULE_18]
   assign O_PERIPH.irq_acknowledge_n = ~ack_on; // [RULE_09]
   assign O_WAIT_N = ~wait_on; // [RULE_10]

   // Helper: cycles since acknowledge began
   logic [7:0] ack_age;
   always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
   begin
      if (!I_RSTN)
         ack_age <= 8'h00;
      else if (!ack_on)
         ack_age <= 8'h00;
      else if (ack_age != 8'hFF)
         ack_age <= ack_age + 8'h01;
   end

   // Saturating age of a held request, cleared when it drops
   function automatic logic [7:0] age_step(input logic run, input logic [7:0] age);
      if (!run)
         age_step = 8'h00;
      else if (age == 8'hFF)
         age_step = age;
      else
         age_step = age + 8'h01;
   endfunction : age_step

   // Helper: cycles each I/O request has been held
   logic [7:0] rd_age;
   logic [7:0] wr_age;
   wire [7:0] next_rd_age = age_step(io_rd_req, rd_age);
   wire [7:0] next_wr_age = age_step(io_wr_req, wr_age);
   always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         rd_age <= 8'h00;
         wr_age <= 8'h00;
      end
      else
      begin
         rd_age <= next_rd_age;
         wr_age <= next_wr_age;
      end
   end

   // Sequences for the acknowledge steps
   sequence ack_entry_s;
      ack_detect && !ack_on;
   endsequence
   sequence ack_rd_due_s;
      ack_on && (ack_age == 8'(ACK_RD)) && !rst_on && !$past(rst_on);
   endsequence
   sequence ack_start_s;
      $fell(O_PERIPH.irq_acknowledge_n) && !O_WAIT_N;
   endsequence
   sequence ack_read_s;
      $fell(O_PERIPH.rd_n) && !O_PERIPH.irq_acknowledge_n;
   endsequence

   // Read fall delayed after request
   rd_fall_delay_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) // [RULE_02]
      (io_rd_req && !$past(io_rd_req) && !rst_on && !ack_rd_on) |-> O_PERIPH.rd_n)
      else $error("peripheral read fell without setup delay");
   // Write fall delayed after request
   wr_fall_delay_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) // [RULE_03]
      (io_wr_req && !$past(io_wr_req) && !rst_on) |-> O_PERIPH.wr_n)
      else $error("peripheral write fell without setup delay");
   // Read ends no later than host read
   rd_early_end_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) // [RULE_04]
      (!host_rd && !rst_on && !ack_rd_on) |-> O_PERIPH.rd_n)
      else $error("peripheral read outlasted host read");
   // Write ends no later than host write
   wr_early_end_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) // [RULE_05]
      (!host_wr && !rst_on) |-> O_PERIPH.wr_n)
      else $error("peripheral write outlasted host write");
   // Select resampled on the clock
   sel_resample_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) // [RULE_06]
      (USE_SYNC_FF != 0) |-> sel == $past(raw_sel))
      else $error("select not resampled");
   // Reset drives both strobes
   hw_reset_both_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) // [RULE_07]
      rst_on |-> (!O_PERIPH.rd_n && !O_PERIPH.wr_n))
      else $error("reset did not drive read and write together");
   // Acknowledge read falls inside acknowledge, after settle time
   ack_order_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) // [RULE_09]
      ack_read_s |-> (ack_age == 8'(ACK_RD)) || rst_on)
      else $error("acknowledge read out of order");
   // Wait starts together with acknowledge
   ack_wait_start_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) // [RULE_10]
      ack_start_s |=> !O_WAIT_N)
      else $error("host not held at acknowledge start");
   // Wait released only after vector valid time
   wait_release_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) // [RULE_19]
      ($rose(O_WAIT_N) && ack_on) |-> (ack_age == 8'(WAIT_TAP)) && !O_PERIPH.rd_n)
      else $error("wait released before vector valid");
   // Settle time counted in whole clocks
   ack_settle_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) // [RULE_11]
      (ack_on && ack_age < 8'(ACK_RD)) |-> !ack_rd_on)
      else $error("acknowledge read before chain settled");
   // Sequencer cleared outside acknowledge
   seq_clear_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) // [RULE_18]
      !host_m1 |=> (stage == SEQ_RESET) || host_m1)
      else $error("sequencer not cleared outside acknowledge");

   // Read held high until the request has aged past the delay
   rd_delay_count_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) // [RULE_02]
      (io_rd_req && rd_age < 8'(STROBE_DLY) && !rst_on && !ack_rd_on) |-> O_PERIPH.rd_n)
      else $error("peripheral read fell before its delay ran out");

   // Held host read reaches the peripheral after the delay
   rd_pass_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) // [RULE_18]
      (io_rd_req && rd_age >= 8'(STROBE_DLY)) |-> !O_PERIPH.rd_n)
      else $error("held host read not passed to peripheral");

   // Write held high until the request has aged past the delay
   wr_delay_count_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) // [RULE_03]
      (io_wr_req && wr_age < 8'(STROBE_DLY) && !rst_on) |-> O_PERIPH.wr_n)
      else $error("peripheral write fell before its delay ran out");

   // Held host write reaches the peripheral after the delay
   wr_pass_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) // [RULE_18]
      (io_wr_req && wr_age >= 8'(STROBE_DLY)) |-> !O_PERIPH.wr_n)
      else $error("held host write not passed to peripheral");

   // Acknowledge and wait follow the early sign by one clock
   ack_entry_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) // [RULE_09]
      ack_entry_s |=> ack_start_s)
      else $error("acknowledge did not start after early sign");

   // Acknowledge read falls exactly at the settle tap
   ack_rd_due_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) // [RULE_11]
      ack_rd_due_s |-> ack_read_s)
      else $error("acknowledge read missed its tap");

   // Host held in wait until the release tap
   wait_hold_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) // [RULE_10]
      (ack_on && ack_age < 8'(WAIT_TAP)) |-> !O_WAIT_N)
      else $error("wait dropped before vector valid time");

   // Acknowledge read stays low once its tap is reached
   ack_rd_hold_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) // [RULE_17]
      (ack_on && ack_age >= 8'(ACK_RD)) |-> !O_PERIPH.rd_n)
      else $error("acknowledge read not held");

   // No write strobe during any opcode fetch
   ack_no_write_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) // [RULE_09]
      (host_m1 && !rst_on) |-> O_PERIPH.wr_n)
      else $error("write strobe during opcode fetch");

   // Acknowledge and wait idle once fetch has ended
   ack_exit_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) // [RULE_18]
      (!host_m1 && $past(!host_m1)) |-> (O_PERIPH.irq_acknowledge_n && O_WAIT_N))
      else $error("acknowledge or wait active outside fetch");

   // Normal fetch with memory request never starts acknowledge
   fetch_idle_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) // [RULE_18]
      (host_m1 && host_mem && !ack_on) |=> O_PERIPH.irq_acknowledge_n)
      else $error("memory fetch started an acknowledge");
endmodule : shg_host_glue
`default_nettype wire

// >>> hw/shg_pkg.sv
// Purpose: Shared constants and carriers for the host-side serial controller glue
// Assumes: Host clock of 50 MHz drives all glue logic
// Notes: Times in ns as printed, cycle counts derived from them
package shg_pkg;
   // Clock period
   localparam int CLK_PERIOD_NS = 20;
   // Strobe timing at the peripheral
   localparam int T_ADDR_SETUP_NS = 50;
   localparam int T_HOST_SETUP_NS = 30;
   // Acknowledge timing at the peripheral and host
   localparam int T_ACK_TO_RD_NS = 130;
   localparam int T_RD_DATA_NS = 120;
   localparam int T_HOST_DATA_SETUP_NS = 25;
   localparam int T_RD_ACK_WIDTH_NS = 125;
   // Least times round up to whole cycles
   localparam int STROBE_DLY_CYC =
      (T_ADDR_SETUP_NS - T_HOST_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACK_RD_CYC = (T_ACK_TO_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RD_VALID_CYC =
      (T_RD_DATA_NS + T_HOST_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RD_WIDTH_CYC = (T_RD_ACK_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Sequencer length and reset value
   localparam int SEQ_LEN = 16;
   localparam logic [15:0] SEQ_RESET = 16'h0000;
   // Host bus strobes, all active low
   typedef struct packed {
      logic rd_n;
      logic wr_n;
      logic io_request_n;
      logic opcode_fetch_n;
      logic mreq_n;
   } shg_host_bus_t;
   // Peripheral-side strobes, all active low
   typedef struct packed {
      logic rd_n;
      logic wr_n;
      logic irq_acknowledge_n;
   } shg_periph_t;
endpackage : shg_pkg

// >>> hw/shg_shift_reg.sv
// Purpose: Clearable serial-in shift register for the acknowledge sequencer
// Assumes: Synchronous clear, asynchronous active-low reset
// Notes: Stage k is high k+1 cycles after the input first went high
`timescale 1ns/10ps
`default_nettype none
module shg_shift_reg
   import shg_pkg::*;
#(
   parameter int LEN = SEQ_LEN
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Control
   input wire logic i_clear,
   input wire logic i_din,
   // Stages
   output logic [LEN-1:0] o_stage
);
   // Elaboration check
   if (LEN < 2) $error("shg_shift_reg: LEN must be at least 2");

   // Next stage value
   wire [LEN-1:0] next_stage = i_clear ? '0 : {o_stage[LEN-2:0], i_din};

   // Stage register
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         o_stage <= '0;
      else
         o_stage <= next_stage;
   end
endmodule : shg_shift_reg
`default_nettype wire
